// ===== rtl/opsi_panel_irq.sv
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "opsi_regs.svh"

// What this block does
// [R01] Lock level at power-on or power return picks running or idle state.
// [R02] Reset release rising with power-fail low raises init firmware irq.
// [R03] Restart pulse on power return only when memory-preserved flag is 1.
// [R04] Timer switch routes inverted clock to level-2 irq, vector 0004.
// [R05] Run pulse falling edge sets panel latch, raising firmware irq.
// [R06] Write 0F with address bit 11 low clears the panel latch.
// [R07] Run request converts incode to loader address for RAM FFF4.
// [R08] On pulse rising edge sets the same latch and firmware irq.
// [R09] Write 0F after on-switch strobes set-request and sets power request.
// [R10] Level-4 request gives code 09FF unless higher code overrides.
// [R11] CPU irq only if incoming level beats program level, enabled, running; external irq needs the level only.
// [R12] Read FF asserts acknowledge and presents level code.
// [R13] Write FF releases acknowledge and loads the program level.
// [R14] Accepted level 4 gives handler vector 0008.
// [R15] Software clears the power request before returning.
// [R16] Write F7 pulses switch-off and drives switch-off output low.
// [R17] In idle, request with firmware mode low drops power line, firmware irq.
// [R18] Idle read F7 strobes set-request, resets request; write F7 switches off.
// [R19] Read F6 returns thumbwheel setting and switch levels as incode.
// [R20] Panel pulses and levels are synchronised before any use.
module opsi_panel_irq (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire opsi_pkg::opsi_bus_t bus_i,
    input wire logic internal_addr_bit11_i,
    output logic [15:0] rd_data_o,
    input wire opsi_pkg::opsi_pins_t pins_i,
    input wire logic firmware_mode_n_i,
    input wire logic global_irq_enable_i,
    input wire logic [5:0] other_level_i,
    output logic firmware_priority_irq_o,
    output logic init_source_n_o,
    output logic auto_restart_o,
    output logic level2_irq_n_o,
    output logic panel_latch_out_n_o,
    output logic set_request_strobe_n_o,
    output logic power_off_request_o,
    output logic [15:0] binary_coded_irq_o,
    output logic external_irq_n_o,
    output logic cpu_irq_n_o,
    output logic irq_ack_strobe_n_o,
    output logic [5:0] ad_level_o,
    output logic [5:0] program_level_o,
    output logic [15:0] irq_vector_o,
    output logic switch_off_pulse_n_o,
    output logic switch_off_out_n_o,
    output logic power_line_off_n_o,
    output logic [15:0] loader_device_select_o,
    output logic [15:0] loader_store_addr_o,
    output logic loader_store_o,
    output logic run_state_o
);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] c);
        hit = (a == c);
    endfunction

    function automatic logic [5:0] lvl_max(input logic [5:0] a,
                                           input logic [5:0] b);
        lvl_max = (a > b) ? a : b;
    endfunction

    // Thumbwheel position becomes the loader parameter address.
    function automatic logic [15:0] loader_addr(input logic [3:0] code);
        logic [7:0] idx;
        idx = `OPSI_LOADER_BASE - {4'h0, code};
        loader_addr = {7'h00, idx, 1'b0};
    endfunction

    logic [13:0] sync1;
    logic [13:0] sync2;
    logic [13:0] prev;
    opsi_pkg::opsi_pins_t s;
    opsi_pkg::opsi_pins_t p;
    logic [1:0] settle;
    logic power_on_pending;
    opsi_pkg::opsi_mode_t mode;
    opsi_pkg::opsi_src_t src;
    logic panel_latch;
    logic init_pend;
    logic power_req;
    logic [5:0] in_level;
    logic ack_active;
    logic switched_off;

    logic wr_panel;
    logic wr_ack;
    logic wr_pwr;
    logic wr_ctrl;
    logic rd_ack;
    logic rd_pwr;
    logic run_fall;
    logic on_rise;
    logic pf_rise;
    logic rsl_rise;
    logic code_clk_rise;
    logic latch_set;
    logic latch_clr;
    logic req_set;
    logic req_clr;
    logic idle_req;
    logic [5:0] req_level;
    logic [5:0] next_in_level;

    // Two-stage synchroniser; the second stage and its delayed copy are decoded, never the first.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= 14'h0000;
            sync2 <= 14'h0000;
            prev <= 14'h0000;
        end else begin
            sync1 <= pins_i; // [R20]
            sync2 <= sync1; // [R20]
            prev <= sync2;
        end
    end

    assign s = sync2;
    assign p = prev;

    assign wr_panel = bus_i.wr && hit(bus_i.addr, `OPSI_ADDR_PANEL);
    assign wr_ack = bus_i.wr && hit(bus_i.addr, `OPSI_ADDR_ACK);
    assign wr_pwr = bus_i.wr && hit(bus_i.addr, `OPSI_ADDR_PWR);
    assign wr_ctrl = bus_i.wr && hit(bus_i.addr, `OPSI_ADDR_CTRL);
    assign rd_ack = bus_i.rd && hit(bus_i.addr, `OPSI_ADDR_ACK);
    assign rd_pwr = bus_i.rd && hit(bus_i.addr, `OPSI_ADDR_PWR);

    // Edges are taken only when the synchronisers hold valid history.
    assign run_fall = (settle == 2'h0) && !s.run_switch_pulse_n
                      && p.run_switch_pulse_n; // [R05]
    assign on_rise = (settle == 2'h0) && s.on_switch_pulse_n
                     && !p.on_switch_pulse_n; // [R08]
    assign pf_rise = (settle == 2'h0) && s.power_fail_n
                     && !p.power_fail_n;
    assign rsl_rise = (settle == 2'h0) && s.reset_release_n
                      && !p.reset_release_n;
    assign code_clk_rise = (settle == 2'h0) && s.irq_code_clock
                           && !p.irq_code_clock;

    assign latch_set = run_fall || on_rise; // [R05] [R08]
    assign latch_clr = wr_panel && !internal_addr_bit11_i; // [R06]
    assign req_set = wr_panel && (src == opsi_pkg::SRC_ON); // [R09]
    assign idle_req = rd_pwr && (mode == opsi_pkg::MODE_IDLE); // [R18]
    assign req_clr = idle_req // [R18]
                     || (wr_ctrl && bus_i.wdata[`OPSI_CT_REQCLR]); // [R15]

    // Our request competes with any other handler's code.
    assign req_level = power_req ? `OPSI_L4_LEVEL : `OPSI_LVL_NONE;
    assign next_in_level = lvl_max(req_level, other_level_i); // [R10]

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            settle <= `OPSI_SETTLE;
        end else if (settle != 2'h0) begin
            settle <= settle - 2'h1;
        end
    end

    // Run or idle choice at power-on and on power return.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_on_pending <= 1'b1;
            mode <= opsi_pkg::MODE_IDLE;
        end else begin
            if ((power_on_pending && settle == 2'h0) || pf_rise) begin
                power_on_pending <= 1'b0;
                mode <= s.lock ? opsi_pkg::MODE_IDLE
                               : opsi_pkg::MODE_RUN; // [R01]
            end else if (wr_ctrl && bus_i.wdata[`OPSI_CT_IDLE]) begin
                mode <= opsi_pkg::MODE_IDLE;
            end else if (wr_ctrl && bus_i.wdata[`OPSI_CT_RUN]) begin
                mode <= opsi_pkg::MODE_RUN;
            end
        end
    end

    // Init source after a power failure; a new event beats a clear.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_pend <= 1'b0;
        end else if (rsl_rise && !s.power_fail_n) begin
            init_pend <= 1'b1; // [R02]
        end else if (wr_ctrl && bus_i.wdata[`OPSI_CT_INITCLR]) begin
            init_pend <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            auto_restart_o <= 1'b0;
        end else begin
            auto_restart_o <= pf_rise
                              && s.memory_preserved_flag; // [R03]
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            level2_irq_n_o <= 1'b1;
        end else begin
            level2_irq_n_o <= !(s.timer_switch_enable
                                && !s.rtc_n); // [R04]
        end
    end

    // Panel latch and the switch that set it.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            panel_latch <= 1'b0;
            src <= opsi_pkg::SRC_NONE;
        end else if (latch_set) begin
            panel_latch <= 1'b1;
            src <= on_rise ? opsi_pkg::SRC_ON : opsi_pkg::SRC_RUN;
        end else if (latch_clr) begin
            panel_latch <= 1'b0; // [R06]
            src <= opsi_pkg::SRC_NONE;
        end
    end

    // Loader parameter address stored on a run request.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            loader_device_select_o <= 16'h0000;
            loader_store_o <= 1'b0;
        end else begin
            loader_store_o <= 1'b0;
            if (wr_panel && src == opsi_pkg::SRC_RUN) begin
                loader_device_select_o <=
                    loader_addr(s.thumbwheel); // [R07]
                loader_store_o <= 1'b1; // [R07]
            end
        end
    end

    // Set-request strobe, one cycle per triggering access.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            set_request_strobe_n_o <= 1'b1;
        end else begin
            set_request_strobe_n_o <= !(req_set || idle_req); // [R09] [R18]
        end
    end

    // Power-off request flop; the set wins over any clear.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_req <= 1'b0;
        end else if (req_set) begin
            power_req <= 1'b1; // [R09]
        end else if (req_clr) begin
            power_req <= 1'b0; // [R18]
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            binary_coded_irq_o <= 16'h0000;
        end else if (power_req && other_level_i <= `OPSI_L4_LEVEL) begin
            binary_coded_irq_o <= `OPSI_L4_CODE; // [R10]
        end else begin
            binary_coded_irq_o <= 16'h0000;
        end
    end

    // Incoming code is taken on each rising edge of the code clock.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_level <= `OPSI_LVL_NONE;
        end else if (code_clk_rise) begin
            in_level <= next_in_level; // [R10]
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            external_irq_n_o <= 1'b1;
            cpu_irq_n_o <= 1'b1;
        end else begin
            external_irq_n_o <= !(in_level > program_level_o); // [R11]
            cpu_irq_n_o <= !((in_level > program_level_o)
                             && global_irq_enable_i
                             && mode == opsi_pkg::MODE_RUN); // [R11] [R17]
        end
    end

    // Acknowledge cycle: read presents the code, write accepts it.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_active <= 1'b0;
            ad_level_o <= `OPSI_LVL_NONE;
        end else if (rd_ack) begin
            ack_active <= 1'b1; // [R12]
            ad_level_o <= in_level; // [R12]
        end else if (wr_ack) begin
            ack_active <= 1'b0; // [R13]
        end
    end

    assign irq_ack_strobe_n_o = !ack_active;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            program_level_o <= `OPSI_LVL_RESET;
        end else if (wr_ack && ack_active) begin
            program_level_o <= ad_level_o; // [R13]
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_vector_o <= `OPSI_VEC_NONE;
        end else if (wr_ack && ack_active) begin
            irq_vector_o <= (ad_level_o == `OPSI_L4_LEVEL)
                            ? `OPSI_VEC_L4 : `OPSI_VEC_NONE; // [R14]
        end else if (!level2_irq_n_o && global_irq_enable_i) begin
            irq_vector_o <= `OPSI_VEC_L2; // [R04]
        end
    end

    // Switch-off pulse and the maintain-mode output it latches.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            switch_off_pulse_n_o <= 1'b1;
            switched_off <= 1'b0;
        end else begin
            switch_off_pulse_n_o <= !wr_pwr; // [R16]
            if (wr_pwr) begin
                switched_off <= 1'b1; // [R16] [R18]
            end
        end
    end

    assign switch_off_out_n_o = !switched_off;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_line_off_n_o <= 1'b1;
        end else begin
            power_line_off_n_o <= !(power_req && !firmware_mode_n_i
                                    && mode == opsi_pkg::MODE_IDLE); // [R17]
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            firmware_priority_irq_o <= 1'b0;
            init_source_n_o <= 1'b1;
            panel_latch_out_n_o <= 1'b1;
        end else begin
            firmware_priority_irq_o <= panel_latch || init_pend // [R05]
                                       || !power_line_off_n_o; // [R17]
            init_source_n_o <= !init_pend; // [R02]
            panel_latch_out_n_o <= !panel_latch; // [R08]
        end
    end

    // Read data stand in the cycle after the strobe only.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= 16'h0000;
        end else if (!bus_i.rd) begin
            rd_data_o <= 16'h0000;
        end else begin
            rd_data_o <= 16'h0000;
            case (bus_i.addr)
                `OPSI_ADDR_INCODE: begin
                    rd_data_o[3:0] <= s.thumbwheel; // [R19]
                    rd_data_o[`OPSI_IN_LOCK] <= s.lock; // [R01]
                    rd_data_o[`OPSI_IN_ARE] <= s.restart_en; // [R03]
                end
                `OPSI_ADDR_ACK: begin
                    rd_data_o[5:0] <= in_level; // [R12]
                end
                `OPSI_ADDR_STATUS: begin
                    rd_data_o[`OPSI_ST_RUN] <= mode;
                    rd_data_o[`OPSI_ST_REQ] <= power_req;
                    rd_data_o[`OPSI_ST_LATCH] <= panel_latch;
                    rd_data_o[`OPSI_ST_ACK] <= ack_active;
                    rd_data_o[`OPSI_ST_INIT] <= init_pend;
                    rd_data_o[`OPSI_ST_SWOFF] <= switched_off;
                    rd_data_o[`OPSI_ST_SRC_ON] <= (src == opsi_pkg::SRC_ON);
                end
                default: begin
                    rd_data_o <= 16'h0000;
                end
            endcase
        end
    end

    assign power_off_request_o = power_req;
    assign run_state_o = mode;
    assign loader_store_addr_o = `OPSI_LOADER_RAM; // [R07]

endmodule // opsi_panel_irq

// ===== rtl/opsi_pkg.sv
package opsi_pkg;

    typedef enum logic [0:0] {
        MODE_IDLE = 1'b0,
        MODE_RUN = 1'b1
    } opsi_mode_t;

    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_RUN = 2'b01,
        SRC_ON = 2'b10
    } opsi_src_t;

    typedef struct packed {
        logic lock;
        logic restart_en;
        logic memory_preserved_flag;
        logic timer_switch_enable;
        logic rtc_n;
        logic run_switch_pulse_n;
        logic on_switch_pulse_n;
        logic reset_release_n;
        logic power_fail_n;
        logic irq_code_clock;
        logic [3:0] thumbwheel;
    } opsi_pins_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } opsi_bus_t;

endpackage

// ===== rtl/opsi_regs.svh
`ifndef OPSI_REGS_SVH
`define OPSI_REGS_SVH

// External register addresses.
`define OPSI_ADDR_PANEL 8'h0F
`define OPSI_ADDR_ACK 8'hFF
`define OPSI_ADDR_PWR 8'hF7
`define OPSI_ADDR_INCODE 8'hF6
`define OPSI_ADDR_STATUS 8'hF8
`define OPSI_ADDR_CTRL 8'hF9

// Level-4 interrupt code and levels.
`define OPSI_L4_CODE 16'h09FF
`define OPSI_L4_LEVEL 6'h04
`define OPSI_LVL_NONE 6'h00
`define OPSI_LVL_RESET 6'h00

// Vectors and loader constants.
`define OPSI_VEC_NONE 16'h0000
`define OPSI_VEC_L2 16'h0004
`define OPSI_VEC_L4 16'h0008
`define OPSI_LOADER_RAM 16'hFFF4
`define OPSI_LOADER_BASE 8'hFF

// Incode data field positions.
`define OPSI_IN_LOCK 4
`define OPSI_IN_ARE 5

// Status field positions.
`define OPSI_ST_RUN 0
`define OPSI_ST_REQ 1
`define OPSI_ST_LATCH 2
`define OPSI_ST_ACK 3
`define OPSI_ST_INIT 4
`define OPSI_ST_SWOFF 5
`define OPSI_ST_SRC_ON 6

// Control field positions.
`define OPSI_CT_RUN 0
`define OPSI_CT_IDLE 1
`define OPSI_CT_REQCLR 2
`define OPSI_CT_INITCLR 3

// Cycles the synchronisers need before first sampling.
`define OPSI_SETTLE 2'h3

`endif

// ===== verification/opsi_panel_irq_asserts.sv
`timescale 1ns/10ps
module opsi_panel_irq_asserts (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire opsi_pkg::opsi_bus_t bus_i,
    input wire logic internal_addr_bit11_i,
    input wire logic firmware_mode_n_i,
    input wire logic [5:0] other_level_i,
    input wire logic panel_latch_out_n_o,
    input wire logic set_request_strobe_n_o,
    input wire logic power_off_request_o,
    input wire logic [15:0] binary_coded_irq_o,
    input wire logic irq_ack_strobe_n_o,
    input wire logic [5:0] ad_level_o,
    input wire logic [5:0] program_level_o,
    input wire logic [15:0] irq_vector_o,
    input wire logic switch_off_pulse_n_o,
    input wire logic switch_off_out_n_o,
    input wire logic power_line_off_n_o,
    input wire logic run_state_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic rd_ff = bus_i.rd && bus_i.addr == 8'hFF;
    wire logic wr_ff = bus_i.wr && bus_i.addr == 8'hFF;
    AST_LATCH_CLR: assert property (
        bus_i.wr && bus_i.addr == 8'h0F && !internal_addr_bit11_i
        |-> ##2 panel_latch_out_n_o) else $error("latch not cleared");
    AST_BINARY_CODE: assert property (
        binary_coded_irq_o != 16'h0000 |-> binary_coded_irq_o == 16'h09FF
        && $past(power_off_request_o) && $past(other_level_i) <= 6'h04)
        else $error("bad binary code");
    AST_ACK_LOW: assert property (
        rd_ff |=> !irq_ack_strobe_n_o) else $error("ack not asserted");
    AST_ACK_REL: assert property (
        wr_ff && !irq_ack_strobe_n_o |=> irq_ack_strobe_n_o
        && program_level_o == $past(ad_level_o))
        else $error("level not taken");
    AST_VEC_L4: assert property (
        $changed(program_level_o) && program_level_o == 6'h04
        |-> irq_vector_o == 16'h0008) else $error("bad level 4 vector");
    AST_SWOFF: assert property (
        bus_i.wr && bus_i.addr == 8'hF7
        |=> !switch_off_pulse_n_o && !switch_off_out_n_o)
        else $error("no switch off");
    AST_PLOF: assert property (
        power_line_off_n_o == !($past(power_off_request_o)
        && !$past(firmware_mode_n_i) && !$past(run_state_o)))
        else $error("bad power line off");
    AST_IDLE_F7: assert property (
        bus_i.rd && bus_i.addr == 8'hF7 && !run_state_o
        |=> !set_request_strobe_n_o && !power_off_request_o)
        else $error("request not reset");
    cover property (rd_ff ##[1:20] wr_ff);
    cover property (!power_line_off_n_o);
    cover property (!switch_off_out_n_o);
endmodule // opsi_panel_irq_asserts

bind opsi_panel_irq opsi_panel_irq_asserts u_chk (.*);

// ===== verification/opsi_panel_model.sv
`timescale 1ns/10ps
module opsi_panel_model (
    input wire logic ref_clk_i,
    output opsi_pkg::opsi_pins_t pins_o
);
    localparam int B_LOCK = 13;
    localparam int B_MEM = 11;
    localparam int B_TMR = 10;
    localparam int B_RTC = 9;
    localparam int B_RUN = 8;
    localparam int B_ON = 7;
    localparam int B_RR = 6;
    localparam int B_PF = 5;
    localparam int B_ICC = 4;
    // Buttons released, supplies good, restart on, thumbwheel at 5.
    opsi_pkg::opsi_pins_t p = 14'h1BE5;
    assign pins_o = p;
    // Each change is held long enough for the board to see it.
    task automatic lines(input int b, input logic v);
        @(posedge ref_clk_i);
        p[b] <= v;
        repeat (6) @(posedge ref_clk_i);
        #1;
    endtask
    // A button gives one low pulse; the on switch acts on its release.
    task automatic press(input int b);
        lines(b, 1'b0);
        lines(b, 1'b1);
    endtask
endmodule // opsi_panel_model

// ===== verification/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    opsi_pkg::opsi_bus_t bus_i = '0;
    opsi_pkg::opsi_pins_t pins_i;
    logic internal_addr_bit11_i = 1'b0;
    logic firmware_mode_n_i = 1'b1;
    logic global_irq_enable_i = 1'b1;
    logic [5:0] other_level_i = 6'h00;
    logic [15:0] rd_data_o, binary_coded_irq_o, irq_vector_o, d;
    logic [15:0] loader_device_select_o, loader_store_addr_o;
    logic [5:0] ad_level_o, program_level_o;
    logic firmware_priority_irq_o, init_source_n_o, auto_restart_o;
    logic level2_irq_n_o, panel_latch_out_n_o, set_request_strobe_n_o;
    logic power_off_request_o, external_irq_n_o, cpu_irq_n_o;
    logic irq_ack_strobe_n_o, switch_off_pulse_n_o, switch_off_out_n_o;
    logic power_line_off_n_o, loader_store_o, run_state_o;
    int n_errors = 0;
    int checks = 0;
    int n_restart = 0;
    opsi_panel_irq dut (.*);
    opsi_panel_model model (.ref_clk_i(ref_clk_i), .pins_o(pins_i));
    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (auto_restart_o === 1'b1) n_restart++;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v,
                      input logic b11);
        @(posedge ref_clk_i);
        bus_i.wr <= 1'b1;
        bus_i.addr <= a;
        bus_i.wdata <= v;
        internal_addr_bit11_i <= b11;
        @(posedge ref_clk_i);
        bus_i.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        bus_i.rd <= 1'b1;
        bus_i.addr <= a;
        @(posedge ref_clk_i);
        bus_i.rd <= 1'b0;
        #1;
        d = rd_data_o;
    endtask
    task automatic do_reset;
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        tick(6);
    endtask
    task automatic t_boot;
        `CHK(run_state_o, 1'b1)
        rd(8'hF6);
        `CHK(d, 16'h0025)
        rd(8'h33);
        `CHK(d, 16'h0000)
        wr(8'hF9, 16'h0002, 1'b0);
        `CHK(run_state_o, 1'b0)
        rd(8'hF8);
        `CHK(d, 16'h0000)
        wr(8'hF9, 16'h0001, 1'b0);
        rd(8'hF8);
        `CHK(d, 16'h0001)
    endtask
    task automatic t_timer;
        model.lines(model.B_TMR, 1'b1);
        model.lines(model.B_RTC, 1'b0);
        `CHK(level2_irq_n_o, 1'b0)
        `CHK(irq_vector_o, 16'h0004)
        model.lines(model.B_TMR, 1'b0);
        `CHK(level2_irq_n_o, 1'b1)
        model.lines(model.B_RTC, 1'b1);
    endtask
    task automatic t_run;
        model.press(model.B_RUN);
        `CHK(panel_latch_out_n_o, 1'b0)
        `CHK(firmware_priority_irq_o, 1'b1)
        wr(8'h0F, 16'h0000, 1'b1);
        tick(2);
        `CHK(panel_latch_out_n_o, 1'b0)
        wr(8'h0F, 16'h0000, 1'b0);
        `CHK(loader_store_o, 1'b1)
        `CHK(loader_store_addr_o, 16'hFFF4)
        tick(8);
        `CHK(loader_device_select_o, 16'h01F4)
        `CHK(panel_latch_out_n_o, 1'b1)
        `CHK(firmware_priority_irq_o, 1'b0)
    endtask
    task automatic t_level4;
        model.press(model.B_ON);
        `CHK(panel_latch_out_n_o, 1'b0)
        wr(8'h0F, 16'h0000, 1'b0);
        `CHK(set_request_strobe_n_o, 1'b0)
        `CHK(power_off_request_o, 1'b1)
        tick(1);
        `CHK(set_request_strobe_n_o, 1'b1)
        `CHK(binary_coded_irq_o, 16'h09FF)
        @(posedge ref_clk_i);
        other_level_i <= 6'h05;
        tick(3);
        `CHK(binary_coded_irq_o, 16'h0000)
        @(posedge ref_clk_i);
        other_level_i <= 6'h00;
        global_irq_enable_i <= 1'b0;
        model.lines(model.B_ICC, 1'b1);
        model.lines(model.B_ICC, 1'b0);
        `CHK(external_irq_n_o, 1'b0)
        `CHK(cpu_irq_n_o, 1'b1)
        @(posedge ref_clk_i);
        global_irq_enable_i <= 1'b1;
        model.lines(model.B_ICC, 1'b1);
        model.lines(model.B_ICC, 1'b0);
        `CHK(cpu_irq_n_o, 1'b0)
        rd(8'hFF);
        `CHK(d[5:0], 6'h04)
        `CHK(ad_level_o, 6'h04)
        `CHK(irq_ack_strobe_n_o, 1'b0)
        wr(8'hFF, 16'h0000, 1'b0);
        `CHK(irq_ack_strobe_n_o, 1'b1)
        `CHK(program_level_o, 6'h04)
        `CHK(irq_vector_o, 16'h0008)
        wr(8'hF9, 16'h0004, 1'b0);
        `CHK(power_off_request_o, 1'b0)
    endtask
    task automatic t_idle;
        model.lines(model.B_LOCK, 1'b1);
        do_reset;
        `CHK(run_state_o, 1'b0)
        model.press(model.B_ON);
        wr(8'h0F, 16'h0000, 1'b0);
        @(posedge ref_clk_i);
        firmware_mode_n_i <= 1'b0;
        model.lines(model.B_ICC, 1'b1);
        model.lines(model.B_ICC, 1'b0);
        `CHK(power_line_off_n_o, 1'b0)
        `CHK(firmware_priority_irq_o, 1'b1)
        `CHK(cpu_irq_n_o, 1'b1)
        rd(8'hF7);
        `CHK(set_request_strobe_n_o, 1'b0)
        `CHK(power_off_request_o, 1'b0)
        tick(2);
        `CHK(power_line_off_n_o, 1'b1)
        wr(8'hF7, 16'h0000, 1'b0);
        `CHK(switch_off_pulse_n_o, 1'b0)
        tick(1);
        `CHK(switch_off_pulse_n_o, 1'b1)
        `CHK(switch_off_out_n_o, 1'b0)
        @(posedge ref_clk_i);
        firmware_mode_n_i <= 1'b1;
    endtask
    task automatic t_power;
        int n0;
        for (int f = 0; f < 2; f++) begin
            model.lines(model.B_MEM, f[0]);
            model.lines(model.B_LOCK, !f[0]);
            model.lines(model.B_PF, 1'b0);
            model.lines(model.B_RR, 1'b0);
            model.lines(model.B_RR, 1'b1);
            `CHK(init_source_n_o, 1'b0)
            `CHK(firmware_priority_irq_o, 1'b1)
            wr(8'hF9, 16'h0008, 1'b0);
            tick(1);
            `CHK(init_source_n_o, 1'b1)
            n0 = n_restart;
            model.lines(model.B_PF, 1'b1);
            `CHK(n_restart - n0, f)
            `CHK(run_state_o, f[0])
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        print_verdict;
    end
    initial begin
        do_reset;
        t_boot;
        t_timer;
        t_run;
        t_level4;
        t_idle;
        t_power;
        print_verdict;
    end
endmodule // tb_top
